/* rtl/spipc_pkg.sv */
// Package for the serial port control and status block.
// Assumes a 200 MHz pclk and a 32-bit APB bus with byte addresses.
package spipc_pkg;

  // Register byte offsets
  localparam logic [7:0] SPIPC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] SPIPC_OFF_STAT  = 8'h04;
  localparam logic [7:0] SPIPC_OFF_BUF   = 8'h08;
  localparam logic [7:0] SPIPC_OFF_IRQST = 8'h0C;
  localparam logic [7:0] SPIPC_OFF_IRQMK = 8'h10;

  // Control register fields
  localparam int SPIPC_CTRL_WRITE_COLLISION_FLAG = 7;
  localparam int SPIPC_CTRL_OV   = 6;
  localparam int SPIPC_CTRL_EN   = 5;
  localparam int SPIPC_CTRL_CKP  = 4;
  localparam int SPIPC_CTRL_MODE = 0;

  // Status register fields
  localparam int SPIPC_STAT_SMP = 7;
  localparam int SPIPC_STAT_CKE = 6;
  localparam int SPIPC_STAT_BF  = 0;

  // Interrupt status and mask fields
  localparam int SPIPC_IRQ_DONE = 0;
  localparam int SPIPC_IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int SPIPC_IRQ_OV   = 2;
  localparam int SPIPC_IRQ_W    = 3;

  // Port mode field codes
  localparam logic [3:0] SPIPC_MODE_MDIV16 = 4'h1;
  localparam logic [3:0] SPIPC_MODE_MDIV64 = 4'h2;
  localparam logic [3:0] SPIPC_MODE_MTMR   = 4'h3;
  localparam logic [3:0] SPIPC_MODE_SLV_SS = 4'h4;
  localparam logic [3:0] SPIPC_MODE_SLV    = 4'h5;

  // Bit clock dividers and half periods less one in pclk cycles
  localparam int         SPIPC_DIV16   = 16;
  localparam int         SPIPC_DIV64   = 64;
  localparam logic [4:0] SPIPC_HALF16  = 5'(SPIPC_DIV16 / 2 - 1);
  localparam logic [4:0] SPIPC_HALF64  = 5'(SPIPC_DIV64 / 2 - 1);

  // Word framing
  localparam int         SPIPC_BITS      = 8;
  localparam logic [4:0] SPIPC_TOGGLES   = 5'(2 * SPIPC_BITS);
  localparam logic [4:0] SPIPC_LAST_CKE1 = 5'(2 * SPIPC_BITS);
  localparam logic [4:0] SPIPC_LAST_CKE0 = 5'(2 * SPIPC_BITS + 1);
  localparam logic [3:0] SPIPC_SLV_LAST  = 4'(SPIPC_BITS);

endpackage

/* rtl/spipc_sync.sv */
// Two-flop synchroniser for one pin input.
// Assumes the pin is asynchronous to pclk; only the second flop is read.
`timescale 1ns/1ps
module spipc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and synchronised level
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic meta;
    logic stable;
  } spipc_sync_t;

  spipc_sync_t q;
  spipc_sync_t next_q;

  always_comb begin
    next_q        = q;
    next_q.meta   = pin;
    next_q.stable = q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {RESET_VAL, RESET_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign level = q.stable;

endmodule

/* rtl/spipc_top.sv */
// Serial port (SPI mode) with control/status registers on APB.
// Assumes pins come from outside pclk domain; timer tick is a pclk pulse.
// Contract
// [RULE_01] Enable bit set: port runs and owns clock, data out, data in pins.
// [RULE_02] Enable bit clear: port stops, pins return to general-purpose use.
// [RULE_03] Clock polarity bit sets serial clock idle level: 1 high, 0 low.
// [RULE_04] Software sets each pin's direction; the port never sets it. The code releases data out (sdo_oe_n high) for a deselected slave.
// [RULE_05] Master: sample phase 1 samples at end, 0 at middle.
// [RULE_06] Software keeps sample phase cleared in slave mode.
// [RULE_07] Idle low: edge select 1 stable on rising, 0 on falling.
// [RULE_08] Mode field: master /16, /64, timer/2; slave with or without select.
// [RULE_09] Idle high: edge select 1 stable on falling, 0 on rising.
// [RULE_10] Buffer full set on receive complete, cleared when buffer read empty.
// [RULE_11] Write collision set on buffer write while busy; software clears.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
module spipc_top
  import spipc_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n,
  output logic             sdo_o,
  output logic             sdo_oe_n,
  input  wire logic        sdi_i,
  input  wire logic        ss_n_i,
  // Pin direction and general-purpose fallback
  input  wire logic        pin_dir_sck,
  input  wire logic        pin_dir_sdo,
  input  wire logic        gpio_sck_o,
  input  wire logic        gpio_sdo_o,
  // Timer two period pulse
  input  wire logic        timer_two_tick,
  // Interrupt
  output logic             irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } spipc_fsm_t;

  typedef struct packed {
    logic                   write_collision_flag;
    logic                   ov;
    logic                   en;
    logic                   clock_idle_polarity;
    logic [3:0]             mode;
    logic                   input_sample_phase;
    logic                   cke;
    logic                   bf;
    logic [7:0]             buffer;
    logic [7:0]             tx_sr;
    logic [7:0]             rx_sr;
    spipc_fsm_t             fsm;
    logic [4:0]             step;
    logic [4:0]             div;
    logic                   sck_act;
    logic                   sck_prev;
    logic [3:0]             scnt;
    logic [SPIPC_IRQ_W-1:0] irq_st;
    logic [SPIPC_IRQ_W-1:0] irq_mask;
    logic [31:0]            rdata;
    logic                   sck_pin;
    logic                   sdo_pin;
  } spipc_state_t;

  spipc_state_t q;
  spipc_state_t next_q;

  logic       sck_s;
  logic       sdi_s;
  logic       ss_n_s;
  logic       is_master;
  logic       is_slave;
  logic       ss_block;
  logic       apb_setup;
  logic       apb_wr;
  logic       apb_rd;
  logic       mapped;
  logic [31:0] rd_val;
  logic [4:0] half_max;
  logic       half_tick;
  logic [7:0] rx_next;

  spipc_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (sck_i),
    .level   (sck_s)
  );

  spipc_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (sdi_i),
    .level   (sdi_s)
  );

  spipc_sync #(.RESET_VAL(1'b1)) u_sync_ss (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ss_n_i),
    .level   (ss_n_s)
  );

  // [RULE_08] mode field decode
  assign is_master = q.en && (q.mode == SPIPC_MODE_MDIV16 || q.mode == SPIPC_MODE_MDIV64 ||
                              q.mode == SPIPC_MODE_MTMR);
  assign is_slave  = q.en && (q.mode == SPIPC_MODE_SLV_SS || q.mode == SPIPC_MODE_SLV);
  assign ss_block  = is_slave && q.mode == SPIPC_MODE_SLV_SS && ss_n_s;
  assign half_max  = (q.mode == SPIPC_MODE_MDIV16) ? SPIPC_HALF16 : SPIPC_HALF64;
  // Timer mode: one tick is one half period, so the bit clock is timer/2
  assign half_tick = is_master && q.fsm == ST_RUN &&
                     ((q.mode == SPIPC_MODE_MTMR) ? timer_two_tick : q.div == half_max);
  assign rx_next   = {q.rx_sr[6:0], sdi_s};

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && penable && !pwrite;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !mapped;

  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == SPIPC_OFF_CTRL) begin
      rd_val[7:0] = {q.write_collision_flag, q.ov, q.en, q.clock_idle_polarity, q.mode};
    end else if (paddr == SPIPC_OFF_STAT) begin
      rd_val[SPIPC_STAT_SMP] = q.input_sample_phase;
      rd_val[SPIPC_STAT_CKE] = q.cke;
      rd_val[SPIPC_STAT_BF]  = q.bf;
    end else if (paddr == SPIPC_OFF_BUF) begin
      rd_val[7:0] = q.buffer;
    end else if (paddr == SPIPC_OFF_IRQST) begin
      rd_val[SPIPC_IRQ_W-1:0] = q.irq_st;
    end else if (paddr == SPIPC_OFF_IRQMK) begin
      rd_val[SPIPC_IRQ_W-1:0] = q.irq_mask;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    logic [4:0] s;
    logic       lead;
    logic       last;
    logic       chg;
    logic       smp_ev;
    logic       sedge;
    logic       slead;
    logic       done;
    s      = q.step + 5'd1;
    lead   = s[0];
    last   = 1'b0;
    chg    = 1'b0;
    smp_ev = 1'b0;
    sedge  = 1'b0;
    slead  = 1'b0;
    done   = 1'b0;
    next_q = q;

    // Read data is captured in the setup cycle, so no wait state
    if (apb_setup) begin
      next_q.rdata = rd_val;
    end

    // Software effects first, so hardware sets below win
    if (apb_wr && paddr == SPIPC_OFF_CTRL) begin
      // [RULE_11] flags clear on written zero only
      next_q.write_collision_flag = q.write_collision_flag & pwdata[SPIPC_CTRL_WRITE_COLLISION_FLAG];
      next_q.ov   = q.ov & pwdata[SPIPC_CTRL_OV];
      next_q.en   = pwdata[SPIPC_CTRL_EN];
      next_q.clock_idle_polarity  = pwdata[SPIPC_CTRL_CKP];
      next_q.mode = pwdata[SPIPC_CTRL_MODE +: 4];
    end else if (apb_wr && paddr == SPIPC_OFF_STAT) begin
      next_q.input_sample_phase = pwdata[SPIPC_STAT_SMP];
      next_q.cke = pwdata[SPIPC_STAT_CKE];
    end else if (apb_wr && paddr == SPIPC_OFF_BUF) begin
      if (q.fsm == ST_RUN || (is_slave && q.scnt != 4'h0)) begin
        // [RULE_11] write while shifting is dropped
        next_q.write_collision_flag = 1'b1;
        next_q.irq_st[SPIPC_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
      end else begin
        next_q.tx_sr = pwdata[7:0];
        if (is_master) begin
          next_q.fsm  = ST_RUN;
          next_q.step = 5'h00;
          next_q.div  = 5'h00;
        end
      end
    end else if (apb_wr && paddr == SPIPC_OFF_IRQST) begin
      next_q.irq_st = q.irq_st & ~pwdata[SPIPC_IRQ_W-1:0];
    end else if (apb_wr && paddr == SPIPC_OFF_IRQMK) begin
      next_q.irq_mask = pwdata[SPIPC_IRQ_W-1:0];
    end

    // [RULE_10] reading the buffer empties it
    if (apb_rd && paddr == SPIPC_OFF_BUF) begin
      next_q.bf = 1'b0;
    end

    // Master engine
    if (q.fsm == ST_RUN && !half_tick) begin
      next_q.div = q.div + 5'd1;
    end
    if (half_tick) begin
      next_q.div  = 5'h00;
      next_q.step = s;
      last = s == (q.cke ? SPIPC_LAST_CKE1 : SPIPC_LAST_CKE0);
      if (s <= SPIPC_TOGGLES) begin
        next_q.sck_act = ~q.sck_act;
      end
      // [RULE_07] [RULE_09] edge select 1: shift on trailing edge
      chg = (q.cke ? !lead : (lead && s > 5'd1)) && s < SPIPC_TOGGLES;
      // [RULE_05] sample at end or middle of output time
      if (q.input_sample_phase) begin
        smp_ev = q.cke ? !lead : (lead && s > 5'd1);
      end else begin
        smp_ev = q.cke ? lead : !lead;
      end
      if (chg) begin
        next_q.tx_sr = {q.tx_sr[6:0], 1'b0};
      end
      if (smp_ev) begin
        next_q.rx_sr = rx_next;
      end
      if (last) begin
        next_q.fsm = ST_IDLE;
        done       = 1'b1;
      end
    end

    // Slave engine on synchronised clock edges
    next_q.sck_prev = sck_s;
    if (ss_block || !is_slave) begin
      next_q.scnt = 4'h0;
    end else begin
      sedge = sck_s != q.sck_prev;
      // [RULE_03] leading edge leaves the idle level
      slead = sck_s != q.clock_idle_polarity;
      // [RULE_07] [RULE_09] slave shift and sample edges
      if (sedge && (q.cke ? !slead : (slead && q.scnt != 4'h0))) begin
        next_q.tx_sr = {q.tx_sr[6:0], 1'b0};
      end
      // [RULE_06] slave always samples at mid-bit
      if (sedge && (q.cke ? slead : !slead)) begin
        next_q.rx_sr = rx_next;
        if (q.scnt == SPIPC_SLV_LAST - 4'h1) begin
          next_q.scnt = 4'h0;
          done        = 1'b1;
        end else begin
          next_q.scnt = q.scnt + 4'h1;
        end
      end
    end

    // [RULE_10] completed word lands in the buffer
    if (done) begin
      if (next_q.bf && is_slave) begin
        // Unread word: new data is lost
        next_q.ov = 1'b1;
        next_q.irq_st[SPIPC_IRQ_OV] = 1'b1;
      end else begin
        next_q.buffer = is_slave ? rx_next : next_q.rx_sr;
        next_q.bf     = 1'b1;
        next_q.irq_st[SPIPC_IRQ_DONE] = 1'b1;
      end
    end

    // [RULE_02] disabling stops any transfer in flight
    if (!next_q.en) begin
      next_q.fsm     = ST_IDLE;
      next_q.scnt    = 4'h0;
      next_q.sck_act = 1'b0;
    end
    if (next_q.en && next_q.mode != q.mode) begin
      next_q.fsm     = ST_IDLE;
      next_q.sck_act = 1'b0;
    end

    // [RULE_01] [RULE_03] pins follow the port when enabled
    next_q.sck_pin = next_q.en ? (next_q.clock_idle_polarity ^ next_q.sck_act) : gpio_sck_o;
    next_q.sdo_pin = next_q.en ? next_q.tx_sr[7] : gpio_sdo_o;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q     <= '0;
      q.fsm <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdata;
  assign sck_o  = q.sck_pin;
  assign sdo_o  = q.sdo_pin;
  // [RULE_04] direction stays with software
  assign sck_oe_n = pin_dir_sck;
  // Unselected slave releases its data line
  assign sdo_oe_n = pin_dir_sdo | ss_block;
  assign irq      = |(q.irq_st & q.irq_mask);

endmodule

/* dv/spipc_properties.sv */
// Checker for the serial port block, bound to spipc_top.
// Assumes control and status change only through APB writes it sees.
`timescale 1ns/1ps
module spipc_properties
  import spipc_pkg::*;
(
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin side
  input wire logic        sck_o,
  input wire logic        sck_oe_n,
  input wire logic        sdo_o,
  input wire logic        pin_dir_sck,
  input wire logic        gpio_sck_o,
  input wire logic        gpio_sdo_o
);
  logic [7:0] ctl;
  logic       cke;
  logic       wr;
  logic       en;
  logic       lead;
  assign wr   = psel && penable && pwrite;
  assign en   = ctl[SPIPC_CTRL_EN];
  assign lead = sck_o != ctl[SPIPC_CTRL_CKP];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      cke <= 1'b0;
    end else if (wr && paddr == SPIPC_OFF_CTRL) begin
      ctl <= pwdata[7:0];
    end else if (wr && paddr == SPIPC_OFF_STAT) begin
      cke <= pwdata[SPIPC_STAT_CKE];
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Settled enable; the first change after enabling is not a bit edge
  sequence toggle_run;
    en && $past(en, 3) && $changed(sck_o);
  endsequence
  sequence half_fast;
    $stable(sck_o) [*7] ##1 $changed(sck_o);
  endsequence
  chk_apb_answer: assert property (psel && penable |->
    pready && pslverr == !(paddr == SPIPC_OFF_CTRL || paddr == SPIPC_OFF_STAT ||
    paddr == SPIPC_OFF_BUF || paddr == SPIPC_OFF_IRQST || paddr == SPIPC_OFF_IRQMK))
    else $error("bad access answer");
  chk_pin_dir: assert property (
    sck_oe_n == pin_dir_sck) else $error("clock direction altered");
  // Pins still hold reset zeros one edge after release
  chk_off_sck: assert property (
    $past(presetn) && !en ##1 !en |-> sck_o == $past(gpio_sck_o))
    else $error("clock pin not released");
  chk_off_sdo: assert property (
    $past(presetn) && !en ##1 !en |-> sdo_o == $past(gpio_sdo_o))
    else $error("data pin not released");
  chk_idle_level: assert property (
    wr && paddr == SPIPC_OFF_CTRL && pwdata[SPIPC_CTRL_EN] |->
    ##2 sck_o == ctl[SPIPC_CTRL_CKP]) else $error("clock idle level wrong");
  chk_data_still: assert property (
    toggle_run ##0 (lead == cke) |-> $stable(sdo_o)) else $error("data moved on edge");
  chk_rate_fast: assert property (
    toggle_run ##0 (lead && ctl[3:0] == SPIPC_MODE_MDIV16) |=> half_fast)
    else $error("fast half period wrong");
  chk_rate_slow: assert property (
    toggle_run ##0 (lead && ctl[3:0] == SPIPC_MODE_MDIV64) |-> ##32 $changed(sck_o))
    else $error("slow half period wrong");
endmodule

/* dv/spipc_partner.sv */
// Far-side device: takes the data out, shifts its own byte back.
// Assumes the bench tells it polarity and phase; it sees the clock on pclk.
`timescale 1ns/1ps
module spipc_partner (
  // Link
  input  wire logic       pclk,
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  // Setup from the bench
  input  wire logic       clock_idle_polarity,
  input  wire logic       cke,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  logic       sck_q = 1'b0;
  logic [7:0] sh    = 8'h00;
  logic [3:0] n     = 4'h0;
  initial begin
    sdi = 1'b0;
    rx  = 8'h00;
  end
  always @(posedge pclk) begin
    sck_q <= sck;
    if (load) begin
      sdi <= tx[7];
      sh  <= {tx[6:0], 1'b0};
      n   <= 4'h0;
    end else if (sck != sck_q && (sck != clock_idle_polarity) == cke) begin
      rx <= {rx[6:0], sdo};
      n  <= n + 4'h1;
    end else if (sck != sck_q && n != 4'h0) begin
      // Past the last bit the line is let go: show a changed level
      sdi <= (n == 4'h8) ? ~sdi : sh[7];
      sh  <= {sh[6:0], 1'b0};
    end
  end
endmodule

/* dv/spipc_tb_top.sv */
// Self-checking bench for the serial port block.
// Assumes the far-side model and the checker bound below.
`timescale 1ns/1ps
module spipc_tb_top;
  import spipc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, cyc = 0, ptx = 0, prx;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        sck_i = 0, ss_n_i = 1, pin_dir_sck = 1, pin_dir_sdo = 1;
  logic        gpio_sck_o = 0, gpio_sdo_o = 0, timer_two_tick = 0, slave = 0;
  logic        slave_sdi = 0, load = 0, clock_idle_polarity = 0, cke = 0, err, psdi;
  logic        pready, pslverr, sck_o, sck_oe_n, sdo_o, sdo_oe_n, irq;
  int          fails = 0, comparisons = 0, tmo = 0;
  wire logic   sdi_i = slave ? slave_sdi : psdi;
  spipc_top DUT (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .sck_i          (sck_i),
    .sck_o          (sck_o),
    .sck_oe_n       (sck_oe_n),
    .sdo_o          (sdo_o),
    .sdo_oe_n       (sdo_oe_n),
    .sdi_i          (sdi_i),
    .ss_n_i         (ss_n_i),
    .pin_dir_sck    (pin_dir_sck),
    .pin_dir_sdo    (pin_dir_sdo),
    .gpio_sck_o     (gpio_sck_o),
    .gpio_sdo_o     (gpio_sdo_o),
    .timer_two_tick (timer_two_tick),
    .irq            (irq)
  );
  spipc_partner PEER (.pclk(pclk), .sck(sck_o), .sdo(sdo_o), .sdi(psdi), .clock_idle_polarity(clock_idle_polarity),
    .cke(cke), .load(load), .tx(ptx), .rx(prx));
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc            <= cyc + 8'h01;
    timer_two_tick <= cyc[1:0] == 2'b00;
    gpio_sck_o     <= cyc[2];
    gpio_sdo_o     <= cyc[4];
    tmo            <= tmo + 1;
    if (tmo == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No local limit: only the bench timeout ends a hung access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic wirq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    cmp({31'h0, irq}, 32'h1);
  endtask
  task automatic mst(input logic [3:0] m, input logic k, e, s, input logic [7:0] t, r);
    apb(1'b1, SPIPC_OFF_CTRL, 32'h0);
    clock_idle_polarity <= k;
    cke <= e;
    ptx <= r;
    apb(1'b1, SPIPC_OFF_STAT, {24'h0, s, e, 6'h0});
    load <= 1'b1;
    apb(1'b1, SPIPC_OFF_CTRL, {24'h0, 3'b001, k, m});
    @(posedge pclk);
    load <= 1'b0;
    cmp({31'h0, sdo_oe_n}, 32'h0);
    apb(1'b1, SPIPC_OFF_BUF, {24'h0, t});
    apb(1'b1, SPIPC_OFF_BUF, 32'h0000_00FF);
    cmp({31'h0, irq}, 32'h0);
    wirq;
    cmp({24'h0, prx}, {24'h0, t});
    cmp({31'h0, sck_o}, {31'h0, k});
    rdc(SPIPC_OFF_CTRL, {24'h0, 3'b101, k, m});
    rdc(SPIPC_OFF_STAT, {24'h0, s, e, 6'h1});
    rdc(SPIPC_OFF_BUF, {24'h0, r});
    rdc(SPIPC_OFF_STAT, {24'h0, s, e, 6'h0});
    rdc(SPIPC_OFF_IRQST, 32'h3);
    apb(1'b1, SPIPC_OFF_IRQST, 32'h3);
    cmp({31'h0, irq}, 32'h0);
  endtask
  // Link clock at 64 ns, running only inside the frame
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      slave_sdi <= b[i];
      #32 sck_i <= 1'b1;
      #32 sck_i <= 1'b0;
    end
    slave_sdi <= ~b[0];
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(SPIPC_OFF_CTRL, 32'h0);
    apb(1'b1, SPIPC_OFF_STAT, 32'h0000_00FF);
    rdc(SPIPC_OFF_STAT, 32'h0000_00C0);
    apb(1'b0, 8'h14, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, SPIPC_OFF_IRQMK, 32'h1);
    pin_dir_sck <= 1'b0;
    pin_dir_sdo <= 1'b0;
    mst(SPIPC_MODE_MDIV16, 1'b0, 1'b1, 1'b0, 8'h3C, 8'hA5);
    mst(SPIPC_MODE_MDIV16, 1'b1, 1'b0, 1'b1, 8'hC3, 8'h5A);
    mst(SPIPC_MODE_MDIV64, 1'b1, 1'b1, 1'b1, 8'h81, 8'h7E);
    mst(SPIPC_MODE_MTMR, 1'b0, 1'b0, 1'b0, 8'h96, 8'h69);
    apb(1'b1, SPIPC_OFF_CTRL, 32'h0);
    repeat (16) @(posedge pclk);
    slave       <= 1'b1;
    pin_dir_sck <= 1'b1;
    apb(1'b1, SPIPC_OFF_STAT, 32'h0000_0040);
    apb(1'b1, SPIPC_OFF_IRQMK, 32'h5);
    apb(1'b1, SPIPC_OFF_CTRL, 32'h0000_0025);
    sbyte(8'hB4);
    wirq;
    rdc(SPIPC_OFF_BUF, 32'h0000_00B4);
    apb(1'b1, SPIPC_OFF_IRQST, 32'h7);
    sbyte(8'h4B);
    sbyte(8'h77);
    rdc(SPIPC_OFF_CTRL, 32'h0000_0065);
    rdc(SPIPC_OFF_IRQST, 32'h5);
    rdc(SPIPC_OFF_BUF, 32'h0000_004B);
    apb(1'b1, SPIPC_OFF_CTRL, 32'h0000_0024);
    // Deselected slave lets its data line go
    cmp({31'h0, sdo_oe_n}, 32'h1);
    ss_n_i <= 1'b0;
    sbyte(8'hE1);
    cmp({31'h0, sdo_oe_n}, 32'h0);
    ss_n_i <= 1'b1;
    rdc(SPIPC_OFF_BUF, 32'h0000_00E1);
    summarize();
  end
endmodule
bind spipc_top spipc_properties CHK (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .sck_o       (sck_o),
  .sck_oe_n    (sck_oe_n),
  .sdo_o       (sdo_o),
  .pin_dir_sck (pin_dir_sck),
  .gpio_sck_o  (gpio_sck_o),
  .gpio_sdo_o  (gpio_sdo_o)
);
